// ===== hw/pha_pkg.sv
package pha_pkg;

    // ------------------------------------------------------------
    // widths and geometry
    // ------------------------------------------------------------
    localparam int ADC_W         = 16;
    localparam int ADDR_W        = 19;
    localparam int TAG_W         = 8;
    localparam int TAG_LSB       = 11;
    localparam int OFFSET_W      = 13;
    localparam int OFFSET_SHIFT  = 6;
    localparam int TIMER_W       = 32;
    localparam int FIFO_DEPTH    = 16;
    localparam int MON_SEL_W     = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 100_000_000;
    localparam int TICK_MS       = 1;
    localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_CNT_W    = 17;
    localparam int PRESET_MIN_MS = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [TIMER_W-1:0] TIMER_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // modes and monitor sources
    // ------------------------------------------------------------
    typedef enum logic { peak_height_mode, sampled_voltage_mode } conv_mode_e;

    typedef enum logic [MON_SEL_W-1:0] {
        mon_window, mon_live, mon_run, mon_tick
    } mon_sel_e;

    // event written to spectrum memory or list stream
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [ADC_W-1:0]  value;
    } event_s;

    // level settings shared by peak and window logic
    typedef struct packed {
        logic [ADC_W-1:0] noise_threshold;
        logic [ADC_W-1:0] lower_level_threshold;
        logic [ADC_W-1:0] upper_level_threshold;
    } levels_s;

endpackage : pha_pkg

// ===== hw/event_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// small synchronous fifo with valid/ready on both sides
// ----------------------------------------------------------------
module event_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != DEPTH[PW:0]);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    // storage
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        end
    end

endmodule : event_fifo

// ===== hw/pulse_height_acquisition_control.sv
`timescale 1ns/1ps
// Function
// - with line watching enabled, a low run line halts the measurement
// - with line output enabled, release line on start, pull low on halt
// - run line is open-drain wired-AND: only pull low or release
// - software enables, disables, sets and resets the run line use
// - two 32-bit timers, live and real, with 1 ms resolution
// - each timer takes a preset from 2 ms to beyond 1193 hours
// - list mode streams events through a fifo instead of histogramming
// - software offset in steps of 64 channels added to memory addresses
// - each of eight I/O bits selectable as label replacing top address bits
// - I/O bit 7 maps to address bit 18, bit 0 to address bit 11
// - label bits captured on activating edge of converter busy
// - conversion from external port up to 16 bits or internal converter
// - peak-height mode converts only peaks inside lower/upper window
// - with gating, acceptance window must be valid at peak
// - peak detection arms only after upward noise threshold crossing
// - no new conversion until input falls below noise threshold
// - sampled mode converts on strobe edge, no window, no window counting
// - sampled mode with gating needs acceptance window valid at strobe edge
// - window counting accepts above noise and lower, below upper threshold
// - window count output routed to first counter input of bin counting
// - window output selectable on any monitor output
module pulse_height_acquisition_control
    import pha_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                ce,
    // software control
    input  wire logic                start_req,
    input  wire logic                halt_req,
    input  wire logic                line_watch_en,
    input  wire logic                line_drive_en,
    input  wire logic                line_force_set,
    input  wire logic                line_force_reset,
    input  wire conv_mode_e          conv_mode,
    input  wire logic                use_external_adc,
    input  wire logic                list_mode,
    input  wire logic                gate_en,
    input  wire logic                gate_polarity,
    input  wire logic                strobe_rising,
    input  wire logic                window_count_en,
    input  wire levels_s             levels,
    input  wire logic [OFFSET_W-1:0] spectrum_offset,
    input  wire logic [TAG_W-1:0]    label_enable,
    input  wire logic [TIMER_W-1:0]  live_preset,
    input  wire logic [TIMER_W-1:0]  real_preset,
    input  wire logic                live_preset_en,
    input  wire logic                real_preset_en,
    input  wire mon_sel_e            mon1_sel,
    input  wire mon_sel_e            mon2_sel,
    // detector side
    input  wire logic [ADC_W-1:0]    internal_sample,
    input  wire logic [ADC_W-1:0]    external_data,
    input  wire logic                external_valid,
    input  wire logic                acceptance_window,
    input  wire logic                conversion_strobe,
    input  wire logic [TAG_W-1:0]    digital_io_in,
    // shared run line, open drain
    input  wire logic                run_line_in,
    output logic                     run_line_out,
    output logic                     run_line_oe,
    // spectrum memory / list stream
    output event_s                   mem_event,
    output logic                     mem_valid,
    input  wire logic                mem_ready,
    output logic                     list_event,
    // status
    output logic                     running,
    output logic                     converter_busy,
    output logic [TIMER_W-1:0]       live_time,
    output logic [TIMER_W-1:0]       real_time,
    output logic                     window_count_pulse,
    output logic                     bin_count1_event,
    output logic                     mon1,
    output logic                     mon2
);

    // --------
    // helpers
    // --------
    function automatic logic level_in_window(input logic [ADC_W-1:0] v,
                                             input levels_s l);
        level_in_window = (v >= l.lower_level_threshold) &&
                          (v <  l.upper_level_threshold);
    endfunction : level_in_window

    function automatic logic gate_ok(input logic en, input logic pol,
                                     input logic win);
        gate_ok = !en || (win == pol);
    endfunction : gate_ok

    function automatic logic mon_pick(input mon_sel_e s, input logic w,
                                      input logic lv, input logic r,
                                      input logic t);
        case (s)
            mon_window: mon_pick = w;
            mon_live:   mon_pick = lv;
            mon_run:    mon_pick = r;
            default:    mon_pick = t;
        endcase
    endfunction : mon_pick

    // --------
    // run control and shared line
    // --------
    typedef enum logic [1:0] { pk_idle, pk_armed, pk_wait_low } peak_e;

    peak_e              peak_state;
    logic [ADC_W-1:0]   peak_value;
    logic [ADC_W-1:0]   prev_sample;
    logic               strobe_q;
    logic               line_forced_low;
    logic               live_hit;
    logic               real_hit;
    logic               stop_now;
    logic               fifo_in_ready;
    logic               conv_fire;
    logic [ADC_W-1:0]   conv_value;
    logic               busy_q;
    logic [TAG_W-1:0]   label_bits;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic               ms_tick;

    // low line only matters when watching it
    assign stop_now = halt_req || (line_watch_en && !run_line_in)
                   || live_hit || real_hit;

    always_ff @(posedge clock) begin
        if (rst) begin
            running <= 1'b0;
        end else if (ce) begin
            if (stop_now) begin
                running <= 1'b0;
            end else if (start_req) begin
                running <= 1'b1;
            end
        end
    end

    // software force, independent of measurement state
    always_ff @(posedge clock) begin
        if (rst) begin
            line_forced_low <= 1'b0;
        end else if (ce) begin
            if (line_force_reset) begin
                line_forced_low <= 1'b1;
            end else if (line_force_set) begin
                line_forced_low <= 1'b0;
            end
        end
    end

    // only ever drive zero; the high level comes from the pull-up
    assign run_line_out = 1'b0;
    assign run_line_oe  = line_forced_low ||
                          (line_drive_en && !running);

    // --------
    // millisecond timebase and timers
    // --------
    always_ff @(posedge clock) begin
        if (rst) begin
            tick_cnt <= '0;
            ms_tick  <= 1'b0;
        end else if (ce) begin
            ms_tick <= 1'b0;
            if (!running) begin
                tick_cnt <= '0;
            end else if (tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1)) begin
                tick_cnt <= '0;
                ms_tick  <= 1'b1;
            end else begin
                tick_cnt <= tick_cnt + 1'b1;
            end
        end
    end

    // presets below the minimum are held at the minimum
    assign live_hit = live_preset_en && running && (live_time >=
        ((live_preset < PRESET_MIN_MS) ? TIMER_W'(PRESET_MIN_MS) : live_preset));
    assign real_hit = real_preset_en && running && (real_time >=
        ((real_preset < PRESET_MIN_MS) ? TIMER_W'(PRESET_MIN_MS) : real_preset));

    always_ff @(posedge clock) begin
        if (rst) begin
            live_time <= TIMER_RESET;
            real_time <= TIMER_RESET;
        end else if (ce) begin
            if (start_req && !running) begin
                live_time <= TIMER_RESET;
                real_time <= TIMER_RESET;
            end else if (ms_tick && running) begin
                real_time <= real_time + 1'b1;
                if (!converter_busy) begin
                    live_time <= live_time + 1'b1;
                end
            end
        end
    end

    // --------
    // internal converter: peak detect and sampled mode
    // --------
    always_ff @(posedge clock) begin
        if (rst) begin
            prev_sample <= '0;
            strobe_q    <= 1'b0;
        end else if (ce) begin
            prev_sample <= internal_sample;
            strobe_q    <= conversion_strobe;
        end
    end

    // conv_fire pulses once per accepted conversion
    always_ff @(posedge clock) begin
        if (rst) begin
            peak_state <= pk_idle;
            peak_value <= '0;
            conv_fire  <= 1'b0;
            conv_value <= '0;
        end else if (ce) begin
            conv_fire <= 1'b0;
            if (use_external_adc) begin
                conv_fire  <= running && external_valid;
                conv_value <= external_data;
                peak_state <= pk_idle;
            end else if (conv_mode == sampled_voltage_mode) begin
                peak_state <= pk_idle;
                if ((conversion_strobe != strobe_q) &&
                    (conversion_strobe == strobe_rising)) begin
                    conv_fire  <= running &&
                        gate_ok(gate_en, gate_polarity, acceptance_window);
                    conv_value <= internal_sample;
                end
            end else begin
                case (peak_state)
                    pk_idle: begin
                        if (internal_sample > levels.noise_threshold &&
                            prev_sample <= levels.noise_threshold) begin
                            peak_state <= pk_armed;
                            peak_value <= internal_sample;
                        end
                    end
                    pk_armed: begin
                        if (internal_sample >= peak_value) begin
                            peak_value <= internal_sample;
                        end else begin
                            // first falling sample marks the peak
                            peak_state <= pk_wait_low;
                            conv_value <= peak_value;
                            conv_fire  <= running &&
                                level_in_window(peak_value, levels) &&
                                gate_ok(gate_en, gate_polarity,
                                        acceptance_window);
                        end
                    end
                    pk_wait_low: begin
                        if (internal_sample <= levels.noise_threshold) begin
                            peak_state <= pk_idle;
                        end
                    end
                    default: peak_state <= pk_idle;
                endcase
            end
        end
    end

    // --------
    // single-channel window counting
    // --------
    // disabled in sampled mode since there is no peak to judge
    always_ff @(posedge clock) begin
        if (rst) begin
            window_count_pulse <= 1'b0;
        end else if (ce) begin
            window_count_pulse <= window_count_en && !use_external_adc &&
                (conv_mode == peak_height_mode) &&
                (peak_state == pk_armed) &&
                (internal_sample < peak_value) &&
                (peak_value > levels.noise_threshold) &&
                level_in_window(peak_value, levels);
        end
    end

    assign bin_count1_event = window_count_pulse;

    // monitor outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            mon1 <= 1'b0;
            mon2 <= 1'b0;
        end else if (ce) begin
            mon1 <= mon_pick(mon1_sel, window_count_pulse, !converter_busy,
                             running, ms_tick);
            mon2 <= mon_pick(mon2_sel, window_count_pulse, !converter_busy,
                             running, ms_tick);
        end
    end

    // --------
    // busy, label capture and address forming
    // --------
    // busy while a converted event waits for the fifo
    always_ff @(posedge clock) begin
        if (rst) begin
            converter_busy <= 1'b0;
            busy_q         <= 1'b0;
            label_bits     <= '0;
        end else if (ce) begin
            busy_q <= converter_busy;
            if (conv_fire) begin
                converter_busy <= 1'b1;
                label_bits     <= digital_io_in;
            end else if (fifo_in_ready) begin
                converter_busy <= 1'b0;
            end
        end
    end

    event_s fifo_in;
    logic   fifo_in_valid;
    logic [ADDR_W-1:0] base_addr;
    logic [ADDR_W-1:0] label_mask;
    logic [ADDR_W-1:0] label_field;

    assign base_addr   = ADDR_W'(conv_value) +
                         (ADDR_W'(spectrum_offset) << OFFSET_SHIFT);
    assign label_mask  = ADDR_W'(label_enable) << TAG_LSB;
    assign label_field = ADDR_W'(label_bits) << TAG_LSB;

    always_comb begin
        fifo_in.value = conv_value;
        fifo_in.addr  = list_mode ? ADDR_W'(conv_value) :
                        ((base_addr & ~label_mask) |
                         (label_field & label_mask));
    end

    // a pending event waits here; further conversions are not stalled by it
    assign fifo_in_valid = converter_busy;

    event_fifo #(
        .WIDTH ($bits(event_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .ce        (ce),
        .in_data   (fifo_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (mem_event),
        .out_valid (mem_valid),
        .out_ready (mem_ready)
    );

    assign list_event = mem_valid && list_mode;

endmodule : pulse_height_acquisition_control

// ===== tb/pulse_source.sv
`timescale 1ns/1ps
// ------
// detector pulse source and the other instruments on the run line
// ------
module pulse_source (
    input  wire logic        clock,
    input  wire logic        fire,
    input  wire logic [15:0] peak,
    input  wire logic        other_pull,
    input  wire logic        dut_oe,
    output logic      [15:0] sample,
    output logic             run_line
);
    logic [3:0] step = 4'h0;
    logic [3:0] shape;

    // nine-step triangle; a refire restarts it so pile-up can be staged
    always_ff @(posedge clock) begin
        if (fire) begin
            step <= 4'h1;
        end else if (step != 4'h0) begin
            step <= (step == 4'h9) ? 4'h0 : step + 4'h1;
        end
    end

    // rises in quarters of the peak, falls back to zero
    assign shape  = (step <= 4'h4) ? step : ((step <= 4'h8) ? 4'h8 - step : 4'h0);
    assign sample = peak[15:2] * shape;

    // pull-up line, anyone may pull it low, nobody drives it high
    assign run_line = ~(dut_oe | other_pull);
endmodule : pulse_source

// ===== tb/pha_chk.sv
`timescale 1ns/1ps
module pha_chk
    import pha_pkg::*;
(
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               ce,
    input wire logic               line_watch_en,
    input wire logic               line_drive_en,
    input wire conv_mode_e         conv_mode,
    input wire logic               list_mode,
    input wire logic               run_line_in,
    input wire logic               run_line_out,
    input wire logic               run_line_oe,
    input wire logic               mem_valid,
    input wire logic               list_event,
    input wire logic               running,
    input wire logic [TIMER_W-1:0] real_time,
    input wire logic               window_count_pulse,
    input wire logic               bin_count1_event
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    line_halt_a: assert property (
        ce && line_watch_en && !run_line_in && running |-> ##[1:2] !running)
        else $error("low run line did not halt");
    drive_low_a: assert property (
        ce && line_drive_en && $fell(running) |-> ##[0:1] run_line_oe)
        else $error("line not pulled on halt");
    line_release_a: assert property (
        ce && line_drive_en && $rose(running) |-> ##[0:1] !run_line_oe)
        else $error("line not released on start");
    open_drain_a: assert property (run_line_out == 1'b0)
        else $error("run line driven high");
    list_flag_a: assert property (list_event == (mem_valid && list_mode))
        else $error("list flag wrong");
    bin_route_a: assert property (bin_count1_event == window_count_pulse)
        else $error("counter input not fed");
    one_pulse_a: assert property (window_count_pulse |=> !window_count_pulse)
        else $error("window pulse too long");
    sampled_quiet_a: assert property (
        conv_mode == sampled_voltage_mode && $past(conv_mode) == sampled_voltage_mode
        |-> !window_count_pulse)
        else $error("window count in sampled mode");
    idle_time_a: assert property (!running && !$past(running) |-> $stable(real_time))
        else $error("real time moved while idle");
endmodule : pha_chk

bind pulse_height_acquisition_control pha_chk pha_chk_inst (.*);

// ===== tb/pulse_height_acquisition_control_bench.sv
`timescale 1ns/1ps
module pulse_height_acquisition_control_bench;
    import pha_pkg::*;

    logic                clock = 1'b0;
    logic                rst   = 1'b1;
    logic                ce, start_req, halt_req, line_watch_en, line_drive_en;
    logic                line_force_set, line_force_reset, use_external_adc, list_mode;
    logic                gate_en, gate_polarity, strobe_rising, window_count_en;
    logic                live_preset_en, real_preset_en, external_valid, acceptance_window;
    logic                conversion_strobe, run_line_in, run_line_out, run_line_oe;
    logic                mem_valid, mem_ready, list_event, running, converter_busy;
    logic                window_count_pulse, bin_count1_event, mon1, mon2, fire, other_pull;
    conv_mode_e          conv_mode;
    mon_sel_e            mon1_sel, mon2_sel;
    levels_s             levels;
    event_s              mem_event, last;
    logic [OFFSET_W-1:0] spectrum_offset;
    logic [TAG_W-1:0]    label_enable, digital_io_in;
    logic [TIMER_W-1:0]  live_preset, real_preset, live_time, real_time;
    logic [ADC_W-1:0]    internal_sample, external_data, peak;
    int                  miscompares = 0, n_tests = 0, pops = 0, wins = 0, p0, w0;

    always #5 clock = ~clock;

    pulse_height_acquisition_control pulse_height_acquisition_control_inst (.*);

    pulse_source pulse_source_inst (
        .clock, .fire, .peak, .other_pull, .dut_oe(run_line_oe),
        .sample(internal_sample), .run_line(run_line_in)
    );

    // count popped events and window pulses, keep the last event
    always @(posedge clock) begin
        if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
            pops <= pops + 1;
            last <= mem_event;
        end
        if (window_count_pulse === 1'b1) wins <= wins + 1;
    end

    task automatic chk(input logic [34:0] got, input logic [34:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // bounded wait for n events, then judge events and window pulses
    task automatic settle(input int n, input int w);
        int k;
        k = 0;
        while (pops - p0 < n && k < 60) begin
            @(posedge clock);
            k++;
        end
        if (pops - p0 < n) begin
            miscompares++;
            end_of_test;
        end
        tick(20);
        chk(pops - p0, n);
        if (w >= 0) chk(wins - w0, w);
    endtask : settle

    // control strobes, packed as start, halt, force set, force reset
    task automatic go(input logic [3:0] r);
        @(posedge clock);
        {start_req, halt_req, line_force_set, line_force_reset} <= r;
        @(posedge clock);
        {start_req, halt_req, line_force_set, line_force_reset} <= 4'h0;
        tick(3);
    endtask : go

    // one detector pulse, a second after gap cycles when gap is nonzero
    task automatic shot(input logic [15:0] p, input int gap);
        p0 = pops;
        w0 = wins;
        @(posedge clock);
        fire <= 1'b1;
        peak <= p;
        @(posedge clock);
        fire <= 1'b0;
        if (gap > 0) begin
            tick(gap);
            fire <= 1'b1;
            @(posedge clock);
            fire <= 1'b0;
        end
    endtask : shot

    task automatic strobe;
        p0 = pops;
        w0 = wins;
        @(posedge clock);
        conversion_strobe <= 1'b1;
        tick(3);
        conversion_strobe <= 1'b0;
    endtask : strobe

    task automatic ext(input logic [15:0] d);
        @(posedge clock);
        external_data  <= d;
        external_valid <= 1'b1;
        @(posedge clock);
        external_valid <= 1'b0;
    endtask : ext

    task automatic line_test;
        line_drive_en <= 1'b1;
        tick(3);
        chk(run_line_oe, 1'b1);
        go(4'h8);
        chk({running, run_line_oe}, 2'h2);
        go(4'h4);
        chk({running, run_line_oe}, 2'h1);
        line_drive_en <= 1'b0;
        line_watch_en <= 1'b1;
        go(4'h8);
        chk(running, 1'b1);
        chk(mon2, 1'b1);
        other_pull <= 1'b1;
        tick(4);
        chk({running, run_line_in}, 2'h0);
        other_pull    <= 1'b0;
        line_watch_en <= 1'b0;
        go(4'h1);
        chk(run_line_oe, 1'b1);
        go(4'h2);
        chk(run_line_oe, 1'b0);
    endtask : line_test

    task automatic peak_test;
        go(4'h8);
        spectrum_offset <= 13'h0003;
        label_enable    <= 8'h81;
        digital_io_in   <= 8'h80;
        window_count_en <= 1'b1;
        shot(16'h0100, 0);
        settle(1, 1);
        chk(last, {19'h401C0, 16'h0100});
        shot(16'h0900, 0);
        settle(0, 0);
        shot(16'h0030, 0);
        settle(0, 0);
        shot(16'h0200, 6);
        settle(1, 1);
        label_enable <= 8'h00;
        shot(16'h0100, 0);
        settle(1, 1);
        chk(last, {19'h001C0, 16'h0100});
        gate_en           <= 1'b1;
        acceptance_window <= 1'b1;
        shot(16'h0100, 0);
        settle(0, -1);
        gate_polarity <= 1'b1;
        shot(16'h0100, 0);
        settle(1, -1);
    endtask : peak_test

    task automatic sampled_test;
        gate_en         <= 1'b0;
        spectrum_offset <= 13'h0001;
        conv_mode       <= sampled_voltage_mode;
        strobe;
        settle(1, 0);
        chk(last, {19'h00040, 16'h0000});
        gate_en           <= 1'b1;
        acceptance_window <= 1'b0;
        strobe;
        settle(0, 0);
        gate_en <= 1'b0;
    endtask : sampled_test

    // the 17th event waits in the converter while the fifo is full
    task automatic ext_test;
        use_external_adc <= 1'b1;
        conv_mode        <= peak_height_mode;
        p0 = pops;
        ext(16'h0123);
        settle(1, -1);
        chk(last, {19'h00163, 16'h0123});
        list_mode <= 1'b1;
        mem_ready <= 1'b0;
        p0 = pops;
        repeat (17) begin
            ext(16'h0123);
            tick(2);
        end
        chk({converter_busy, mem_valid}, 2'h3);
        mem_ready <= 1'b1;
        settle(17, -1);
        chk(last, {19'h00123, 16'h0123});
    endtask : ext_test

    initial begin
        {start_req, halt_req, line_watch_en, line_drive_en, line_force_set, line_force_reset,
         use_external_adc, list_mode, gate_en, gate_polarity, strobe_rising, window_count_en,
         external_valid, acceptance_window, conversion_strobe, fire, other_pull} = '0;
        {ce, mem_ready, live_preset_en, real_preset_en} = 4'hF;
        conv_mode = peak_height_mode;
        mon1_sel  = mon_window;
        mon2_sel  = mon_run;
        levels    = {16'h0040, 16'h0080, 16'h0800};
        {spectrum_offset, label_enable, digital_io_in} = '0;
        {live_preset, real_preset} = {32'h0001_0000, 32'h0001_0000};
        {external_data, peak} = '0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        line_test;
        peak_test;
        sampled_test;
        ext_test;
        end_of_test;
    end
endmodule : pulse_height_acquisition_control_bench
